// ---- include/power_reset_consts.vh ----
// Constants for the power mode and reset sequencer.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef POWER_RESET_CONSTS_VH
`define POWER_RESET_CONSTS_VH

// Register offsets on the plain register port
`define PCTL_ADDR        8'h87
`define WDCTL_ADDR       8'hD8
`define WDSEL_ADDR       8'hD9
`define IRQCTL_ADDR      8'hDA

// Power control fields
`define PCTL_IDLE_BIT    0
`define PCTL_PD_BIT      1
`define PCTL_RESET       8'h00

// Watchdog control fields
`define WD_RESTART_BIT   0
`define WD_RSTEN_BIT     1
`define WD_RSTFLAG_BIT   2
`define WD_IRQFLAG_BIT   3
`define WD_ENABLE_BIT    4
`define WD_POR_BIT       6

// Interrupt control fields
`define IRQ_GLOBAL_BIT   0
`define IRQ_EXT_EN_BIT   1
`define IRQ_EXT_EDGE_BIT 2
`define IRQ_WD_EN_BIT    3

// Timing
`define CLK_PER_MC       4
`define EXT_RST_MIN_MC   2
`define WD_HOLD_MC       2
`define WD_GRACE_CLK     512
`define WD_SEL_RESET     2'h0
`define RESET_VECTOR     16'h0000
`define FOURTH_STATE     2'h3

`endif

// ---- design/power_reset_sequencer.v ----
// Power mode and reset sequencer: idle and power-down control, external,
// power-on and watchdog reset sequencing with cause flags.
// Assumes one 20 MHz clock, inputs synchronous to it, and a CPU that obeys
// cpu_clock_enable, cpu_reset and wake pulses from this block.
`include "power_reset_consts.vh"
`default_nettype none

module power_reset_sequencer #(
	parameter WD_GRACE = `WD_GRACE_CLK
) (
	input  wire       clock,
	input  wire       nrst,
	input  wire       supply_ok,
	input  wire       reset_pin,
	input  wire       ext_irq_pin,
	input  wire       irq_pending,
	input  wire       ext_fetch,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output reg  [7:0] rdata,
	output reg        cpu_clock_enable,
	output reg        periph_clock_enable,
	output reg        cpu_reset,
	output reg        wake_pulse,
	output reg        addr_latch_strobe,
	output reg        prog_store_strobe,
	output reg        port0_oe_n,
	output reg        port2_drive_address,
	output reg        watchdog_irq,
	output reg  [1:0] machine_state
);

	localparam ST_RUN  = 4'b0001;
	localparam ST_IDLE = 4'b0010;
	localparam ST_PD   = 4'b0100;
	localparam ST_RST  = 4'b1000;

	// Counts sized to their registers so no bits are dropped silently
	localparam [1:0] EXT_HOLD = `EXT_RST_MIN_MC;
	localparam [9:0] WD_HOLD_CLK = `WD_HOLD_MC * `CLK_PER_MC - 1;

	reg  [3:0]  state;
	reg  [7:0]  power_control_reg;
	reg         wd_enable;
	reg         watchdog_reset_enable;
	reg         watchdog_reset_flag;
	reg         wd_irq_flag;
	reg         power_on_flag;
	reg  [1:0]  wd_select;
	reg         global_irq_enable;
	reg         ext_irq_enable;
	reg         ext_irq_edge;
	reg         wd_irq_enable;
	reg  [19:0] wd_count;
	reg  [9:0]  grace_count;
	reg         grace_run;
	reg  [1:0]  pin_high_mc;
	reg  [1:0]  hold_mc;
	reg         ext_rst_active;
	reg         wd_hold;
	reg         irq_prev;
	reg         por_done;
	wire        mc_end;
	wire        wd_timeout;
	wire        ext_wake;
	wire        wd_restart;
	reg  [19:0] wd_limit;

	// Machine cycle phase, four states per cycle
	assign mc_end = (machine_state == `FOURTH_STATE);

	// Interval select; longer intervals than 2^20 would need a parameter
	always @* begin
		case (wd_select)
			2'h0:    wd_limit = 20'h0FFFF;
			2'h1:    wd_limit = 20'h1FFFF;
			2'h2:    wd_limit = 20'h3FFFF;
			default: wd_limit = 20'hFFFFF;
		endcase
	end

	assign wd_timeout = wd_enable && (wd_count == wd_limit);
	assign wd_restart = wr && (addr == `WDCTL_ADDR) && wdata[`WD_RESTART_BIT];

	// External interrupt wake qualification; sense level or falling edge
	assign ext_wake = global_irq_enable && ext_irq_enable &&
		(ext_irq_edge ? (irq_prev && !ext_irq_pin) : !ext_irq_pin);

	// Supply monitor drives the async reset; recovery is a power-on reset
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			machine_state <= 2'h0;
			por_done      <= 1'b0;
		end else begin
			// Stopped in Power-Down, resumes from state one
			if (state == ST_PD)
				machine_state <= 2'h0;
			else
				machine_state <= machine_state + 2'h1;
			por_done <= 1'b1;
		end
	end

	// External reset pin qualification and stretch
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pin_high_mc    <= 2'h0;
			hold_mc        <= 2'h0;
			ext_rst_active <= 1'b0;
		end else if (mc_end || state == ST_PD) begin
			// Power-Down has no machine cycles; the pin is taken directly
			if (reset_pin) begin
				if (pin_high_mc != `EXT_RST_MIN_MC)
					pin_high_mc <= pin_high_mc + 2'h1;
				if (pin_high_mc + 2'h1 >= `EXT_RST_MIN_MC || state == ST_PD) begin
					ext_rst_active <= 1'b1;
					hold_mc        <= EXT_HOLD;
				end
			end else begin
				pin_high_mc <= 2'h0;
				// Release on the second low sample, so at most two cycles
				if (hold_mc > 2'h1)
					hold_mc <= hold_mc - 2'h1;
				else begin
					hold_mc        <= 2'h0;
					ext_rst_active <= 1'b0;
				end
			end
		end
	end

	// Watchdog counter, grace period and reset hold
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wd_count    <= 20'h00000;
			grace_count <= 10'h000;
			grace_run   <= 1'b0;
			wd_hold     <= 1'b0;
		end else if (state == ST_PD) begin
			grace_run <= 1'b0; // Clock stopped: no watchdog reset
		end else if (wd_restart || state == ST_RST) begin
			wd_count  <= 20'h00000;
			grace_run <= 1'b0;
			// Hold counted in clocks, so it lasts two whole machine cycles
			if (wd_hold) begin
				if (grace_count == 10'h001)
					wd_hold <= 1'b0;
				grace_count <= grace_count - 10'h001;
			end
		end else if (grace_run) begin
			if (grace_count == WD_GRACE[9:0] - 10'h001) begin
				grace_run <= 1'b0;
				if (watchdog_reset_enable) begin
					wd_hold     <= 1'b1;
					grace_count <= WD_HOLD_CLK;
				end
			end else
				grace_count <= grace_count + 10'h001;
		end else if (wd_enable) begin
			if (wd_timeout) begin
				wd_count    <= 20'h00000;
				grace_run   <= 1'b1;
				grace_count <= 10'h000;
			end else
				wd_count <= wd_count + 20'h00001;
		end
	end

	// Mode sequencing; external reset outranks any wake-up
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state      <= ST_RST;
			wake_pulse <= 1'b0;
			irq_prev   <= 1'b1;
		end else begin
			wake_pulse <= 1'b0;
			irq_prev   <= ext_irq_pin;
			case (state)
				ST_RUN: begin
					if (ext_rst_active || wd_hold)
						state <= ST_RST;
					else if (wr && addr == `PCTL_ADDR && wdata[`PCTL_PD_BIT])
						state <= ST_PD;
					else if (wr && addr == `PCTL_ADDR && wdata[`PCTL_IDLE_BIT])
						state <= ST_IDLE;
				end
				ST_IDLE: begin
					if (ext_rst_active || wd_hold)
						state <= ST_RST;
					else if (irq_pending || ext_wake) begin
						state      <= ST_RUN;
						wake_pulse <= 1'b1;
					end
				end
				ST_PD: begin
					if (ext_rst_active)
						state <= ST_RST;
					else if (ext_wake) begin
						state      <= ST_RUN;
						wake_pulse <= 1'b1;
					end
				end
				ST_RST: begin
					if (!ext_rst_active && !wd_hold && por_done)
						state <= ST_RUN; // Restart at the reset vector
				end
				default: state <= ST_RST;
			endcase
		end
	end

	// Registers; cause flags and watchdog_reset_enable alone depend on reset source
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			power_control_reg     <= `PCTL_RESET;
			wd_enable             <= 1'b0;
			watchdog_reset_enable <= 1'b0;
			watchdog_reset_flag   <= 1'b0;
			power_on_flag         <= 1'b1;
			wd_irq_flag           <= 1'b0;
			wd_select             <= `WD_SEL_RESET;
			global_irq_enable     <= 1'b0;
			ext_irq_enable        <= 1'b0;
			ext_irq_edge          <= 1'b0;
			wd_irq_enable         <= 1'b0;
		end else if (state == ST_RST) begin
			// External reset leaves both cause flags alone
			power_control_reg <= `PCTL_RESET;
			wd_enable         <= 1'b0;
			wd_irq_flag       <= 1'b0;
			wd_select         <= `WD_SEL_RESET;
			global_irq_enable <= 1'b0;
			ext_irq_enable    <= 1'b0;
			ext_irq_edge      <= 1'b0;
			wd_irq_enable     <= 1'b0;
			if (wd_hold)
				watchdog_reset_flag <= 1'b1;
		end else begin
			// Wake clears the mode bits by hardware
			if (wake_pulse)
				power_control_reg[1:0] <= 2'h0;
			else if (wr && addr == `PCTL_ADDR)
				power_control_reg <= wdata;
			if (wr && addr == `WDCTL_ADDR) begin
				watchdog_reset_enable <= wdata[`WD_RSTEN_BIT];
				watchdog_reset_flag   <= wdata[`WD_RSTFLAG_BIT];
				power_on_flag         <= wdata[`WD_POR_BIT];
				wd_enable             <= wdata[`WD_ENABLE_BIT];
			end
			// Time-out set wins over a software clear
			if (wd_timeout && state != ST_PD)
				wd_irq_flag <= 1'b1;
			else if (wr && addr == `WDCTL_ADDR)
				wd_irq_flag <= wdata[`WD_IRQFLAG_BIT];
			if (wr && addr == `WDSEL_ADDR)
				wd_select <= wdata[1:0];
			if (wr && addr == `IRQCTL_ADDR) begin
				global_irq_enable <= wdata[`IRQ_GLOBAL_BIT];
				ext_irq_enable    <= wdata[`IRQ_EXT_EN_BIT];
				ext_irq_edge      <= wdata[`IRQ_EXT_EDGE_BIT];
				wd_irq_enable     <= wdata[`IRQ_WD_EN_BIT];
			end
		end
	end

	// Read port, data one cycle after the strobe; unmapped reads zero
	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			rdata <= 8'h00;
		else if (rd) begin
			case (addr)
				`PCTL_ADDR:   rdata <= power_control_reg;
				`WDCTL_ADDR:  rdata <= {1'b0, power_on_flag, 1'b0, wd_enable,
					wd_irq_flag, watchdog_reset_flag, watchdog_reset_enable, 1'b0};
				`WDSEL_ADDR:  rdata <= {6'h00, wd_select};
				`IRQCTL_ADDR: rdata <= {4'h0, wd_irq_enable, ext_irq_edge,
					ext_irq_enable, global_irq_enable};
				default:      rdata <= 8'h00;
			endcase
		end else
			rdata <= 8'h00;
	end

	// Clock gating and pin states per mode, all registered
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cpu_clock_enable    <= 1'b0;
			periph_clock_enable <= 1'b1;
			cpu_reset           <= 1'b1;
			addr_latch_strobe   <= 1'b1;
			prog_store_strobe   <= 1'b1;
			port0_oe_n          <= 1'b1;
			port2_drive_address <= 1'b0;
			watchdog_irq        <= 1'b0;
		end else begin
			cpu_clock_enable    <= (next_state_run(state, ext_rst_active, wd_hold));
			periph_clock_enable <= (state != ST_PD);
			cpu_reset           <= (state == ST_RST);
			addr_latch_strobe   <= (state != ST_PD);
			prog_store_strobe   <= (state != ST_PD);
			port0_oe_n          <= ext_fetch && (state == ST_IDLE || state == ST_PD);
			port2_drive_address <= ext_fetch && (state == ST_IDLE);
			watchdog_irq        <= wd_irq_flag && wd_irq_enable && global_irq_enable;
		end
	end

	// CPU clock runs only in run mode outside reset
	function next_state_run;
		input [3:0] st;
		input       ext_rst;
		input       wdh;
		begin
			next_state_run = (st == ST_RUN) && !ext_rst && !wdh;
		end
	endfunction

endmodule

`default_nettype wire

// ---- testbench/psq_far_side.sv ----
// Far side model: supply monitor, reset button and interrupt line.
// Assumes the bench raises its requests between clock edges.
`default_nettype none
module psq_far_side (
	input  wire logic clock,
	input  wire logic supply_good,
	input  wire logic rst_req,
	input  wire logic irq_req,
	output wire logic supply_ok,
	output wire logic nrst,
	output wire logic reset_pin,
	output wire logic ext_irq_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] held = 4'h0;
	// Supply monitor drives the power-on reset straight from the rail
	assign supply_ok = supply_good;
	assign nrst = supply_good;
	// Line idles high on its pull-up, pulled low to request
	assign ext_irq_pin = !irq_req;
	// A press is stretched to two machine cycles, so it is never too short
	always @(posedge clock) begin
		if (rst_req)
			held <= 4'h8;
		else if (held != 4'h0)
			held <= held - 4'h1;
	end
	assign reset_pin = rst_req || (held != 4'h0);
endmodule
`default_nettype wire

// ---- testbench/psq_properties.sv ----
// Port checker for the power mode and reset sequencer.
// Assumes the sequencer's single clock and async reset; bound below.
`include "power_reset_consts.vh"
`default_nettype none
module psq_properties (
	input wire logic       clock,
	input wire logic       nrst,
	input wire logic       reset_pin,
	input wire logic       irq_pending,
	input wire logic       ext_fetch,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       cpu_clock_enable,
	input wire logic       periph_clock_enable,
	input wire logic       cpu_reset,
	input wire logic       wake_pulse,
	input wire logic       addr_latch_strobe,
	input wire logic       prog_store_strobe,
	input wire logic       port0_oe_n,
	input wire logic       port2_drive_address,
	input wire logic [1:0] machine_state
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	wire pd = !periph_clock_enable;
	a_idle_strobes_high: assert property (!cpu_clock_enable && !pd |-> addr_latch_strobe
		&& prog_store_strobe) else $error("strobe low outside power-down");
	a_pd_strobes_low: assert property (pd |-> !addr_latch_strobe && !prog_store_strobe)
		else $error("strobe high in power-down");
	a_pd_all_frozen: assert property (pd |-> !cpu_clock_enable && machine_state == 2'h0)
		else $error("activity in power-down");
	a_pd_port_state: assert property (pd && $past(pd) && ext_fetch && $past(ext_fetch)
		|-> port0_oe_n && !port2_drive_address) else $error("port state in power-down");
	a_idle_entry_time: assert property (wr && addr == `PCTL_ADDR && wdata == 8'h01
		&& cpu_clock_enable && !cpu_reset && !reset_pin && !irq_pending ##1 !irq_pending
		|-> ##1 !cpu_clock_enable && !pd) else $error("idle not entered");
	a_phase_steps: assert property ($past(nrst) && !pd && !$past(pd)
		|-> machine_state == $past(machine_state) + 2'h1) else $error("phase skipped");
	a_wake_one_cycle: assert property (wake_pulse |=> !wake_pulse)
		else $error("wake pulse too long");
	a_pin_min_width: assert property (reset_pin && !$past(reset_pin) && !pd && !cpu_reset
		|-> !cpu_reset [*4]) else $error("reset applied too early");
	a_pin_reset_taken: assert property ((reset_pin && !pd) [*8] |-> ##[0:4] cpu_reset)
		else $error("held pin gave no reset");
	a_pin_reset_exit: assert property ($fell(reset_pin) && cpu_reset |-> ##[1:16] !cpu_reset)
		else $error("reset held too long");
	a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00) else $error("stray read data");
	c_wake: cover property (wake_pulse);
	c_power_down: cover property (pd);
	c_reset: cover property ($rose(cpu_reset));
endmodule
bind power_reset_sequencer psq_properties u_props (.clock, .nrst, .reset_pin, .irq_pending,
	.ext_fetch, .addr, .wdata, .wr, .rd, .rdata, .cpu_clock_enable, .periph_clock_enable,
	.cpu_reset, .wake_pulse, .addr_latch_strobe, .prog_store_strobe, .port0_oe_n,
	.port2_drive_address, .machine_state);
`default_nettype wire

// ---- testbench/power_mode_and_reset_sequencer_tb_top.sv ----
// Self-checking bench for the power mode and reset sequencer.
// Assumes the far side model and the checker are compiled before it.
`include "power_reset_consts.vh"
`default_nettype none
module power_mode_and_reset_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int GRACE = 8; // Short grace keeps the watchdog run brief
	localparam int CPU = 0, PER = 1, RST = 2, WAKE = 3, WDI = 4;
	logic clock = 1'b0, supply_good = 1'b0, rst_req = 1'b0, irq_req = 1'b0;
	logic irq_pending = 1'b0, ext_fetch = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic nrst, supply_ok, reset_pin, ext_irq_pin, cpu_clock_enable, periph_clock_enable;
	logic cpu_reset, wake_pulse, addr_latch_strobe, prog_store_strobe, port0_oe_n;
	logic port2_drive_address, watchdog_irq;
	logic [1:0] machine_state;
	int num_errors = 0, check_count = 0, n = 0;
	always #25 clock = ~clock;
	psq_far_side far (.clock, .supply_good, .rst_req, .irq_req, .supply_ok, .nrst,
		.reset_pin, .ext_irq_pin);
	power_reset_sequencer #(.WD_GRACE(GRACE)) uut (.clock, .nrst, .supply_ok, .reset_pin,
		.ext_irq_pin, .irq_pending, .ext_fetch, .addr, .wdata, .wr, .rd, .rdata,
		.cpu_clock_enable, .periph_clock_enable, .cpu_reset, .wake_pulse, .addr_latch_strobe,
		.prog_store_strobe, .port0_oe_n, .port2_drive_address, .watchdog_irq, .machine_state);
	task results;
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function logic pick(input int sel);
		case (sel)
			CPU: return cpu_clock_enable;
			PER: return periph_clock_enable;
			RST: return cpu_reset;
			WAKE: return wake_pulse;
			default: return watchdog_irq;
		endcase
	endfunction
	// Bounded wait; n keeps the cycle count for timing checks
	task wait_on(input int sel, input logic v, input int lim);
		n = 0;
		while (pick(sel) !== v) begin
			@(posedge clock);
			#1;
			n++;
			if (n > lim) begin
				check(pick(sel), v);
				results();
			end
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 check(rdata & m, e);
	endtask
	task pin_reset;
		rst_req <= 1'b1;
		wait_on(RST, 1'b1, 14);
		rst_req <= 1'b0;
		wait_on(RST, 1'b0, 24);
	endtask
	task t_power_on;
		rd_chk(`WDCTL_ADDR, 8'h46, 8'h40);
		rd_chk(`PCTL_ADDR, 8'hFF, `PCTL_RESET);
		rd_chk(8'h00, 8'hFF, 8'h00); // Unmapped place reads zero
		wr_reg(`WDCTL_ADDR, 8'h00);
		rd_chk(`WDCTL_ADDR, 8'h40, 8'h00);
	endtask
	task t_idle;
		wr_reg(`PCTL_ADDR, 8'h01);
		wait_on(CPU, 1'b0, 8);
		check(periph_clock_enable, 1'b1);
		check({addr_latch_strobe, prog_store_strobe, port0_oe_n, port2_drive_address}, 8'h0F);
		irq_pending <= 1'b1;
		wait_on(WAKE, 1'b1, 8);
		irq_pending <= 1'b0;
		wait_on(CPU, 1'b1, 8);
		rd_chk(`PCTL_ADDR, 8'hFF, 8'h00);
	endtask
	task t_idle_reset;
		wr_reg(`IRQCTL_ADDR, 8'h01);
		wr_reg(`PCTL_ADDR, 8'h01);
		wait_on(CPU, 1'b0, 8);
		pin_reset();
		wait_on(CPU, 1'b1, 4);
		rd_chk(`PCTL_ADDR, 8'hFF, 8'h00);
		rd_chk(`IRQCTL_ADDR, 8'hFF, 8'h00);
		rd_chk(`WDCTL_ADDR, 8'h44, 8'h00);
	endtask
	task t_power_down;
		wr_reg(`IRQCTL_ADDR, 8'h03);
		wr_reg(`PCTL_ADDR, 8'h02);
		wait_on(PER, 1'b0, 8);
		irq_pending <= 1'b1;
		repeat (8) @(posedge clock);
		#1 check(periph_clock_enable, 1'b0);
		check({addr_latch_strobe, prog_store_strobe, port0_oe_n, port2_drive_address}, 8'h02);
		irq_pending <= 1'b0;
		irq_req <= 1'b1;
		wait_on(WAKE, 1'b1, 12);
		irq_req <= 1'b0;
		wait_on(CPU, 1'b1, 8);
		rd_chk(`PCTL_ADDR, 8'hFF, 8'h00);
		wr_reg(`PCTL_ADDR, 8'h02);
		wait_on(PER, 1'b0, 8);
		pin_reset();
		wait_on(CPU, 1'b1, 8);
	endtask
	task t_watchdog;
		wr_reg(`WDSEL_ADDR, 8'h00);
		wr_reg(`IRQCTL_ADDR, 8'h09);
		wr_reg(`WDCTL_ADDR, 8'h13);
		wait_on(WDI, 1'b1, 65600);
		check(n > 65500, 1'b1);
		wait_on(RST, 1'b1, GRACE + 8);
		check(n >= GRACE - 1 && n <= GRACE + 4, 1'b1);
		wait_on(RST, 1'b0, 16);
		check(n >= 7 && n <= 10, 1'b1);
		rd_chk(`WDCTL_ADDR, 8'h44, 8'h04);
	endtask
	task t_supply;
		supply_good <= 1'b0;
		repeat (4) @(posedge clock);
		supply_good <= 1'b1;
		wait_on(CPU, 1'b1, 8);
		rd_chk(`WDCTL_ADDR, 8'h46, 8'h40);
	endtask
	// Power-up reset for four cycles, then every scenario in turn
	initial begin
		repeat (4) @(posedge clock);
		supply_good <= 1'b1;
		ext_fetch <= 1'b1;
		wait_on(CPU, 1'b1, 8);
		t_power_on();
		t_idle();
		t_idle_reset();
		t_power_down();
		t_watchdog();
		t_supply();
		results();
	end
endmodule
`default_nettype wire
